//--- src/gtm_consts.svh
// register offsets, field positions and reset values of the timer half
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH
`define GTM_OFF_CTRL 12'h000
`define GTM_OFF_MODE 12'h004
`define GTM_OFF_LOAD 12'h008
`define GTM_OFF_MATCH 12'h00c
`define GTM_OFF_PRESC 12'h010
`define GTM_OFF_VALUE 12'h014
`define GTM_OFF_MASK 12'h018
`define GTM_OFF_RAW 12'h01c
`define GTM_OFF_MIS 12'h020
`define GTM_OFF_CLR 12'h024
`define GTM_CTL_EN 0
`define GTM_CTL_STALL 1
`define GTM_CTL_EVT_LO 2
`define GTM_CTL_EVT_HI 3
`define GTM_CTL_OTE 5
`define GTM_CTL_INV 6
`define GTM_MD_MR_LO 0
`define GTM_MD_MR_HI 1
`define GTM_MD_CMR 2
`define GTM_MD_AMS 3
`define GTM_IRQ_TO 0
`define GTM_IRQ_CM 1
`define GTM_IRQ_CE 2
`define GTM_LOAD_RST 16'hffff
`define GTM_PRESC_RST 8'h00
`endif

//--- src/gtm_pkg.sv
// types shared by the timer half
package gtm_pkg;
  typedef enum logic [1:0] {
    GTM_MR_NONE = 2'h0,
    GTM_MR_ONESHOT = 2'h1,
    GTM_MR_PERIODIC = 2'h2,
    GTM_MR_CAPTURE = 2'h3
  } gtm_mr_e;
  typedef enum logic [1:0] {
    GTM_EV_RISE = 2'h0,
    GTM_EV_FALL = 2'h1,
    GTM_EV_BOTH = 2'h3
  } gtm_ev_e;
  typedef enum logic [4:0] {
    GTM_ST_IDLE = 5'h01,
    GTM_ST_TIMER = 5'h02,
    GTM_ST_ECNT = 5'h04,
    GTM_ST_ETIME = 5'h08,
    GTM_ST_PWM = 5'h10
  } gtm_st_e;
endpackage : gtm_pkg

//--- src/gtm_timer_half.sv
// one 16-bit timer half with apb registers, capture/compare pin and pwm
`include "gtm_consts.svh"
module gtm_timer_half
  import gtm_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CAP_PIN,
  input wire logic STALL_IN,
  output logic PWM_OUT,
  output logic TRIG_OUT,
  output logic IRQ
);
  logic [6:0] ctrl_q;
  logic [3:0] mode_q;
  logic [15:0] load_q;
  logic [15:0] match_q;
  logic [7:0] presc_q;
  logic [15:0] value_q;
  logic [2:0] mask_q;
  logic [2:0] raw_q;
  logic [15:0] cnt_q;
  logic [7:0] pcnt_q;
  logic load_pend_q;
  logic [2:0] pin_q;
  logic stall_s1_q;
  logic stall_s2_q;
  logic pwm_q;
  gtm_st_e st;
  logic acc;
  logic wr;
  logic mapped;
  logic rise;
  logic fall;
  logic edge_hit;
  logic tick;
  logic run;
  logic at_zero;
  logic cm_hit;
  logic en_clr;
  logic [2:0] set_ev;
  logic [2:0] clr_ev;
  logic [2:0] raw_d;
  logic [2:0] mask_d;
  gtm_mr_e mr;

  assign mr = gtm_mr_e'(mode_q[`GTM_MD_MR_HI:`GTM_MD_MR_LO]);
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE && !PREADY;

  // mode decode; pwm takes priority since it shares the periodic code
  always_comb begin
    if (!ctrl_q[`GTM_CTL_EN]) begin
      st = GTM_ST_IDLE;
    end else if (mode_q[`GTM_MD_AMS] && !mode_q[`GTM_MD_CMR] && mr == GTM_MR_PERIODIC) begin
      st = GTM_ST_PWM;
    end else if (mr == GTM_MR_CAPTURE) begin
      st = mode_q[`GTM_MD_CMR] ? GTM_ST_ETIME : GTM_ST_ECNT;
    end else if (mr == GTM_MR_ONESHOT || mr == GTM_MR_PERIODIC) begin
      st = GTM_ST_TIMER;
    end else begin
      st = GTM_ST_IDLE;
    end
  end

  // pin and stall pass two flops; only the second stage and later are read
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pin_q <= 3'h0;
      stall_s1_q <= 1'b0;
      stall_s2_q <= 1'b0;
    end else begin
      pin_q <= {pin_q[1:0], CAP_PIN};
      stall_s1_q <= STALL_IN;
      stall_s2_q <= stall_s1_q;
    end
  end

  // edge detect from successive synchronised samples, one event per clock
  assign rise = pin_q[1] && !pin_q[2];
  assign fall = !pin_q[1] && pin_q[2];
  always_comb begin
    case (gtm_ev_e'(ctrl_q[`GTM_CTL_EVT_HI:`GTM_CTL_EVT_LO]))
      GTM_EV_RISE: edge_hit = rise;
      GTM_EV_FALL: edge_hit = fall;
      GTM_EV_BOTH: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // prescaler only for timer and pwm modes; edge time steps every clock
  assign run = !(ctrl_q[`GTM_CTL_STALL] && stall_s2_q);
  assign tick = (st == GTM_ST_ETIME) ? 1'b1 : (pcnt_q == 8'h00);
  assign at_zero = (cnt_q == 16'h0000);
  assign cm_hit = (st == GTM_ST_ECNT) && edge_hit && (cnt_q - 16'h0001 == match_q);
  assign en_clr = cm_hit || (st == GTM_ST_TIMER && run && tick && at_zero
                  && mr == GTM_MR_ONESHOT);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pcnt_q <= `GTM_PRESC_RST;
    end else if (st == GTM_ST_IDLE || load_pend_q) begin
      pcnt_q <= presc_q;
    end else if ((st == GTM_ST_TIMER || st == GTM_ST_PWM) && run) begin
      pcnt_q <= (pcnt_q == 8'h00) ? presc_q : pcnt_q - 8'h01;
    end
  end

  // main counter; a load write is taken on the next clock in every mode
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cnt_q <= `GTM_LOAD_RST;
    end else if (load_pend_q) begin
      cnt_q <= load_q;
    end else begin
      case (st)
        GTM_ST_TIMER, GTM_ST_PWM, GTM_ST_ETIME: begin
          if (run && tick) begin
            cnt_q <= at_zero ? load_q : cnt_q - 16'h0001;
          end
        end
        GTM_ST_ECNT: begin
          if (cm_hit) begin
            cnt_q <= load_q;
          end else if (edge_hit) begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          cnt_q <= cnt_q; // idle: counting stopped, edges ignored
        end
      endcase
    end
  end

  // load-write marker so the counter follows the new interval next cycle
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      load_pend_q <= 1'b0;
    end else begin
      load_pend_q <= wr && PADDR == `GTM_OFF_LOAD;
    end
  end

  // in edge time the captured count holds until the next selected edge; other modes track the count every clock
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      value_q <= `GTM_LOAD_RST;
    end else if (st == GTM_ST_ETIME) begin
      if (edge_hit) begin
        value_q <= cnt_q;
      end
    end else begin
      value_q <= cnt_q;
    end
  end

  // hardware events; pwm mode raises none
  always_comb begin
    set_ev = 3'h0;
    set_ev[`GTM_IRQ_TO] = st == GTM_ST_TIMER && run && tick && at_zero;
    set_ev[`GTM_IRQ_CM] = cm_hit;
    set_ev[`GTM_IRQ_CE] = st == GTM_ST_ETIME && edge_hit;
    clr_ev = (wr && PADDR == `GTM_OFF_CLR) ? PWDATA[2:0] : 3'h0;
    raw_d = (raw_q & ~clr_ev) | set_ev; // set beats clear
    mask_d = (wr && PADDR == `GTM_OFF_MASK) ? PWDATA[2:0] : mask_q;
  end

  // sticky flags, write one to clear; a set in the same cycle wins
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      raw_q <= 3'h0;
    end else begin
      raw_q <= raw_d;
    end
  end

  // irq from next flags and next mask, so a mask write never leaves it a cycle behind
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(raw_d & mask_d);
    end
  end

  // output trigger registered from the zero event, so it lands one clock after the zero cycle
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      TRIG_OUT <= 1'b0;
    end else begin
      TRIG_OUT <= set_ev[`GTM_IRQ_TO] && ctrl_q[`GTM_CTL_OTE];
    end
  end

  // pwm level: set at start value, clear at match value
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pwm_q <= 1'b0;
    end else if (st != GTM_ST_PWM) begin
      pwm_q <= 1'b0;
    end else if (cnt_q == load_q) begin
      pwm_q <= 1'b1;
    end else if (cnt_q == match_q) begin
      pwm_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PWM_OUT <= 1'b0;
    end else begin
      PWM_OUT <= pwm_q ^ ctrl_q[`GTM_CTL_INV];
    end
  end

  // software-written registers; hardware clear of enable beats a write
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_q <= 7'h00;
      mode_q <= 4'h0;
      load_q <= `GTM_LOAD_RST;
      match_q <= 16'h0000;
      presc_q <= `GTM_PRESC_RST;
      mask_q <= 3'h0;
    end else begin
      if (wr) begin
        case (PADDR)
          `GTM_OFF_CTRL: ctrl_q <= PWDATA[6:0];
          `GTM_OFF_MODE: mode_q <= PWDATA[3:0];
          `GTM_OFF_LOAD: load_q <= PWDATA[15:0];
          `GTM_OFF_MATCH: match_q <= PWDATA[15:0];
          `GTM_OFF_PRESC: presc_q <= PWDATA[7:0];
          `GTM_OFF_MASK: mask_q <= PWDATA[2:0];
          default: ;
        endcase
      end
      if (en_clr) begin
        ctrl_q[`GTM_CTL_EN] <= 1'b0;
      end
    end
  end

  // apb slave: one wait state, read data registered, unmapped gives error
  always_comb begin
    case (PADDR)
      `GTM_OFF_CTRL, `GTM_OFF_MODE, `GTM_OFF_LOAD, `GTM_OFF_MATCH, `GTM_OFF_PRESC,
      `GTM_OFF_VALUE, `GTM_OFF_MASK, `GTM_OFF_RAW, `GTM_OFF_MIS, `GTM_OFF_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= acc && !PREADY;
      PSLVERR <= acc && !PREADY && !mapped;
      PRDATA <= 32'h0000_0000;
      if (acc && !PREADY && !PWRITE) begin
        case (PADDR)
          `GTM_OFF_CTRL: PRDATA <= {25'h0, ctrl_q};
          `GTM_OFF_MODE: PRDATA <= {28'h0, mode_q};
          `GTM_OFF_LOAD: PRDATA <= {16'h0, load_q};
          `GTM_OFF_MATCH: PRDATA <= {16'h0, match_q};
          `GTM_OFF_PRESC: PRDATA <= {24'h0, presc_q};
          `GTM_OFF_VALUE: PRDATA <= {16'h0, value_q};
          `GTM_OFF_MASK: PRDATA <= {29'h0, mask_q};
          `GTM_OFF_RAW: PRDATA <= {29'h0, raw_q};
          `GTM_OFF_MIS: PRDATA <= {29'h0, raw_q & mask_q};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks
  property p_to_sticky;
    @(posedge REF_CLK) disable iff (!RST_N)
      set_ev[`GTM_IRQ_TO] |=> raw_q[`GTM_IRQ_TO];
  endproperty
  a_to_sticky: assert property (p_to_sticky) else $error("timeout flag not set");

  property p_irq;
    @(posedge REF_CLK) disable iff (!RST_N)
      (raw_q[`GTM_IRQ_TO] && mask_q[`GTM_IRQ_TO]) |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("masked timeout gives no irq");

  property p_trig;
    @(posedge REF_CLK) disable iff (!RST_N)
      TRIG_OUT |=> !TRIG_OUT;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger wider than one cycle");

  property p_load;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wr && PADDR == `GTM_OFF_LOAD) |=> ##1 (cnt_q == $past(PWDATA[15:0], 2));
  endproperty
  a_load: assert property (p_load) else $error("counter missed new load");

  property p_stall;
    @(posedge REF_CLK) disable iff (!RST_N)
      (st == GTM_ST_TIMER && !run && !load_pend_q) |=> $stable(cnt_q);
  endproperty
  a_stall: assert property (p_stall) else $error("counter moved while stalled");

  property p_cm_stop;
    @(posedge REF_CLK) disable iff (!RST_N)
      cm_hit |=> (!ctrl_q[`GTM_CTL_EN] && raw_q[`GTM_IRQ_CM]);
  endproperty
  a_cm_stop: assert property (p_cm_stop) else $error("edge count did not stop");

  property p_capture;
    @(posedge REF_CLK) disable iff (!RST_N)
      (st == GTM_ST_ETIME && edge_hit) |=> (value_q == $past(cnt_q));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_pwm_quiet;
    @(posedge REF_CLK) disable iff (!RST_N)
      (st == GTM_ST_PWM && raw_q == 3'h0) |=> (raw_q == 3'h0 && !IRQ);
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm raised a flag");

  property p_idle_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
      (st == GTM_ST_IDLE && !load_pend_q) |=> $stable(cnt_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counter moved while off");

  property p_etime_step;
    @(posedge REF_CLK) disable iff (!RST_N)
      (st == GTM_ST_ETIME && run && !load_pend_q && !at_zero)
      |=> (cnt_q == $past(cnt_q) - 16'h0001);
  endproperty
  a_etime_step: assert property (p_etime_step) else $error("edge time step missed");

  property p_trig_zero;
    @(posedge REF_CLK) disable iff (!RST_N)
      (st == GTM_ST_TIMER && run && tick && at_zero && ctrl_q[`GTM_CTL_OTE]) |=> TRIG_OUT;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("no trigger at zero");

  c_timeout: cover property (@(posedge REF_CLK) disable iff (!RST_N) set_ev[`GTM_IRQ_TO]);
  c_match: cover property (@(posedge REF_CLK) disable iff (!RST_N) cm_hit);
  c_capture: cover property (@(posedge REF_CLK) disable iff (!RST_N) set_ev[`GTM_IRQ_CE]);
  c_pwm: cover property (@(posedge REF_CLK) disable iff (!RST_N) $rose(PWM_OUT));
  c_stall: cover property (@(posedge REF_CLK) disable iff (!RST_N) st == GTM_ST_TIMER && !run);
endmodule : gtm_timer_half

//--- verif/gtm_pin_model.sv
// stand-in for the outside signal on the capture/compare pin
module gtm_pin_model (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pin idles low between bursts
  initial pin = 1'b0;
  // n pulses, each level held h clocks so the two-flop stage sees it
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      pin <= 1'b1;
      repeat (h) @(posedge clk);
      pin <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask : pulses
endmodule : gtm_pin_model

//--- verif/gtm_timer_half_bench.sv
// self-checking bench for the 16-bit timer half
`include "gtm_consts.svh"
module gtm_timer_half_bench
  import gtm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, STALL_IN, slverr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, CAP_PIN, PWM_OUT, TRIG_OUT, IRQ;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  gtm_timer_half DUT (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .CAP_PIN, .STALL_IN, .PWM_OUT, .TRIG_OUT, .IRQ);
  gtm_pin_model pin (.clk(REF_CLK), .pin(CAP_PIN));

  // 100 ns clock
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  // cycle stamp, used to predict captured counts
  always @(posedge REF_CLK) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; request held until pready is sampled, then a gap edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int t;
    t = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
      t++;
    end while (PREADY !== 1'b1);
    chk(t, 2); // one wait state: pready is seen at the second access edge
    q = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask : rc

  // stop first: mode changes while running are not supported
  task automatic setup(input logic [31:0] md, ld, mt, pr, mk);
    wr(`GTM_OFF_CTRL, 32'h0);
    wr(`GTM_OFF_CLR, 32'h7);
    wr(`GTM_OFF_MODE, md);
    wr(`GTM_OFF_LOAD, ld);
    wr(`GTM_OFF_MATCH, mt);
    wr(`GTM_OFF_PRESC, pr);
    wr(`GTM_OFF_MASK, mk);
  endtask : setup

  // clocks from one trigger pulse to the next, 3000 if none follows
  task automatic trig_gap(output int n);
    int t;
    t = 0;
    while (TRIG_OUT !== 1'b1 && t < 3000) begin
      @(posedge REF_CLK);
      t++;
    end
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (TRIG_OUT !== 1'b1 && n < 3000);
  endtask : trig_gap

  // high clocks of the pwm pin over 100 clocks, after settling
  task automatic hi_count(output int n);
    n = 0;
    repeat (20) @(posedge REF_CLK);
    repeat (100) begin
      @(posedge REF_CLK);
      n += (PWM_OUT === 1'b1);
    end
  endtask : hi_count

  task automatic s_reset();
    logic [31:0] q;
    rc(`GTM_OFF_LOAD, 32'hffff);
    rc(`GTM_OFF_VALUE, 32'hffff);
    rc(`GTM_OFF_PRESC, 32'h0);
    apb(1'b0, 12'h028, 32'h0, q);
    chk({31'h0, slverr}, 32'h1);
  endtask : s_reset

  task automatic s_oneshot();
    int n;
    setup(32'h1, 32'h14, 32'h0, 32'h0, 32'h1);
    wr(`GTM_OFF_CTRL, 32'h21);
    trig_gap(n);
    chk(n, 3000);
    chk({31'h0, IRQ}, 32'h1);
    rc(`GTM_OFF_RAW, 32'h1);
    rc(`GTM_OFF_MIS, 32'h1);
    rc(`GTM_OFF_CTRL, 32'h20);
    wr(`GTM_OFF_CLR, 32'h1);
    rc(`GTM_OFF_RAW, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
  endtask : s_oneshot

  task automatic s_periodic();
    int n;
    logic [31:0] v, w;
    setup(32'h2, 32'h3, 32'h0, 32'h3, 32'h0);
    wr(`GTM_OFF_CTRL, 32'h21);
    trig_gap(n);
    chk(n, 16);
    rc(`GTM_OFF_CTRL, 32'h21);
    setup(32'h2, 32'h3, 32'h0, 32'hff, 32'h0);
    wr(`GTM_OFF_CTRL, 32'h21);
    trig_gap(n);
    chk(n, 1024);
    // live reload, then stall on the running count
    setup(32'h2, 32'h1000, 32'h0, 32'h0, 32'h0);
    wr(`GTM_OFF_CTRL, 32'h3);
    wr(`GTM_OFF_LOAD, 32'h80);
    rd(`GTM_OFF_VALUE, v);
    chk({31'h0, v <= 32'h80 && v > 32'h70}, 32'h1);
    STALL_IN <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    rd(`GTM_OFF_VALUE, v);
    repeat (10) @(posedge REF_CLK);
    rc(`GTM_OFF_VALUE, v);
    STALL_IN <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    rd(`GTM_OFF_VALUE, w);
    chk({31'h0, w < v}, 32'h1);
  endtask : s_periodic

  task automatic s_ecount();
    gtm_ev_e evs[3] = '{GTM_EV_RISE, GTM_EV_FALL, GTM_EV_BOTH};
    logic b;
    foreach (evs[i]) begin
      b = (evs[i] == GTM_EV_BOTH);
      setup(32'h3, 32'ha, 32'h6, 32'h0, 32'h2);
      wr(`GTM_OFF_CTRL, {28'h0, evs[i], 2'h1});
      pin.pulses(2, 3);
      repeat (4) @(posedge REF_CLK);
      rc(`GTM_OFF_VALUE, b ? 32'ha : 32'h8);
      rc(`GTM_OFF_RAW, b ? 32'h2 : 32'h0);
      pin.pulses(2, 3);
      repeat (4) @(posedge REF_CLK);
      rc(`GTM_OFF_VALUE, 32'ha);
      rc(`GTM_OFF_MIS, 32'h2);
      rc(`GTM_OFF_CTRL, {28'h0, evs[i], 2'h0});
    end
  endtask : s_ecount

  task automatic s_etime();
    int t1, t2;
    logic [31:0] v, w;
    setup(32'h7, 32'h63, 32'h0, 32'hff, 32'h4);
    wr(`GTM_OFF_CTRL, 32'h1);
    t1 = cyc;
    pin.pulses(1, 10);
    rd(`GTM_OFF_VALUE, v);
    rc(`GTM_OFF_RAW, 32'h4);
    chk({31'h0, IRQ}, 32'h1);
    rc(`GTM_OFF_VALUE, v);
    t2 = cyc;
    pin.pulses(1, 10);
    rd(`GTM_OFF_VALUE, w);
    chk(w, (v + 100 - (t2 - t1) % 100) % 100);
  endtask : s_etime

  task automatic s_pwm();
    int n;
    setup(32'ha, 32'h9, 32'h2, 32'h0, 32'h7);
    wr(`GTM_OFF_CTRL, 32'h1);
    hi_count(n);
    chk(n, 70);
    rc(`GTM_OFF_RAW, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    wr(`GTM_OFF_CTRL, 32'h41);
    hi_count(n);
    chk(n, 30);
  endtask : s_pwm

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the run needs about 6000 clocks
  initial begin
    #2000000;
    err_count++;
    $display("ERROR %0t: timeout", $time);
    print_verdict();
  end

  // reset for ten clocks, then the scenarios
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    STALL_IN = 1'b0;
    repeat (10) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    s_reset();
    s_oneshot();
    s_periodic();
    s_ecount();
    s_etime();
    s_pwm();
    print_verdict();
  end
endmodule : gtm_timer_half_bench
